// ==== logic/irq_ctrl_pkg.sv ====
// Constants, register map and types of the two-level interrupt controller
package irq_ctrl_pkg;

	// Register byte addresses
	localparam logic [7:0] TMRCTL_ADDR     = 8'h88;
	localparam logic [7:0] IRQEN_ADDR      = 8'hA8;
	localparam logic [7:0] IRQPRI_ADDR     = 8'hB8;
	localparam logic [7:0] XFLAG_ADDR      = 8'hC0;
	localparam logic [7:0] AUXFLAG_ADDR    = 8'hC4;
	localparam logic [7:0] CORESTATE_ADDR  = 8'hC8;
	localparam logic [7:0] EVT_STATUS_ADDR = 8'hD0;
	localparam logic [7:0] EVT_CLEAR_ADDR  = 8'hD4;
	localparam logic [7:0] EVT_ENABLE_ADDR = 8'hDC;
	localparam logic [7:0] XIRQEN_ADDR     = 8'hE8;
	localparam logic [7:0] XIRQPRI_ADDR    = 8'hF8;

	// Reset values
	localparam logic [7:0] TMRCTL_RST  = 8'h00;
	localparam logic [7:0] IRQEN_RST   = 8'h00;
	localparam logic [7:0] IRQPRI_RST  = 8'h00;
	localparam logic [7:0] XIRQEN_RST  = 8'h00;
	localparam logic [7:0] XIRQPRI_RST = 8'h00;
	localparam logic [7:0] FLAG_RST    = 8'h00;
	localparam logic [7:0] EVT_RST     = 8'h00;

	// Implemented bits
	localparam logic [7:0] IRQEN_MASK  = 8'hBF;
	localparam logic [7:0] IRQPRI_MASK = 8'h3F;
	localparam logic [7:0] XIRQ_MASK   = 8'h1B;
	localparam logic [7:0] EVT_MASK    = 8'h07;

	// Timer control and trigger fields
	localparam int TC_EXT0_EDGE = 0;
	localparam int TC_EXT0_FLAG = 1;
	localparam int TC_EXT1_EDGE = 2;
	localparam int TC_EXT1_FLAG = 3;
	localparam int TC_TMR0_FLAG = 5;
	localparam int TC_TMR1_FLAG = 7;

	// Enable register global bit, extended fields
	localparam int IEN_GLOBAL = 7;
	localparam int XB_EXT2    = 0;
	localparam int XB_EXT3    = 1;
	localparam int XB_NET     = 3;
	localparam int XB_WDT     = 4;

	// Auxiliary flag fields
	localparam int AF_RX   = 0;
	localparam int AF_TX   = 1;
	localparam int AF_TMR2 = 2;
	localparam int AF_WDT  = 3;

	// Event status fields
	localparam int EV_REQ     = 0;
	localparam int EV_PREEMPT = 1;
	localparam int EV_STRAY   = 2;

	// Sources in natural priority order, index 0 first
	localparam int NUM_SRC = 10;
	localparam logic [79:0] VECTORS = {8'h63, 8'h5B, 8'h4B, 8'h43, 8'h2B,
		8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03};
	localparam logic [39:0] NUMBERS = {4'hC, 4'hB, 4'h9, 4'h8, 4'h5,
		4'h4, 4'h3, 4'h2, 4'h1, 4'h0};

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Request presented to the processor core
	typedef struct packed {
		logic       req;
		logic       high;
		logic [3:0] number;
		logic [7:0] vector;
	} core_irq_t;

endpackage

// ==== logic/pin_edge_sync.sv ====
// Two-stage synchroniser with falling-edge detect for active-low pins
`timescale 1ns/100ps
module pin_edge_sync
	import irq_ctrl_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// Pins and synchronised results
	input  wire logic [WIDTH-1:0] pin_n,
	output logic      [WIDTH-1:0] level_n,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("pin_edge_sync needs at least one pin");
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end
		else
		begin
			meta_q <= pin_n;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// High to low seen on the synchronised level
	assign level_n = sync_q;
	assign fall    = prev_q & ~sync_q;

endmodule

// ==== logic/two_level_irq_ctrl.sv ====
// Two-level interrupt controller with AXI4-Lite register access
`timescale 1ns/100ps
module two_level_irq_ctrl
	import irq_ctrl_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              RESET,
	// AXI4-Lite write address and data
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              WVALID,
	output logic                   WREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	// AXI4-Lite write response
	output logic                   BVALID,
	input  wire logic              BREADY,
	output logic [1:0]             BRESP,
	// AXI4-Lite read
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	output logic                   RVALID,
	input  wire logic              RREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	// External interrupt pins
	input  wire logic              EXT_IRQ0_PIN_N,
	input  wire logic              EXT_IRQ1_PIN_N,
	input  wire logic              EXT_IRQ2_PIN_N,
	input  wire logic              EXT_IRQ3_PIN_N,
	// On-chip sources
	input  wire logic              NET_ENGINE_IRQ_N,
	input  wire logic              TMR0_OVERFLOW,
	input  wire logic              TMR1_OVERFLOW,
	input  wire logic              TMR2_EVENT,
	input  wire logic              SERIAL_TX_DONE,
	input  wire logic              SERIAL_RX_DONE,
	input  wire logic              WATCHDOG_EVENT,
	// Processor core
	input  wire logic              INT_ACK,
	input  wire logic              INT_RETURN,
	output core_irq_t              CORE_IRQ,
	// Event interrupt
	output logic                   IRQ
);

	if (ADDR_W < 8 || ADDR_W > 32)
	begin : g_bad_addr
		$error("ADDR_W must be 8 to 32");
	end

	// Flag next value, hardware set wins over any clear
	function automatic logic flag_next(input logic q, input logic set,
		input logic wr, input logic wbit, input logic hwclr);
		flag_next = set | (wr ? wbit : (q & ~hwclr));
	endfunction

	// Lowest set index of a source mask
	function automatic logic [3:0] first_src(input logic [NUM_SRC-1:0] m);
		first_src = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (m[i])
			begin
				first_src = 4'(i);
			end
		end
	endfunction

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		addr_is = (a == ADDR_W'(off));
	endfunction

	// Bus state
	logic              awready_q;
	logic              aw_full_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic              wready_q;
	logic              w_full_q;
	logic [7:0]        wdata_q;
	logic              wlane_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              arready_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	// Control and flag registers
	logic [7:0]         ien_q;
	logic [7:0]         ipri_q;
	logic [7:0]         xen_q;
	logic [7:0]         xpri_q;
	logic               ext0_edge_select_q;
	logic               ext1_edge_select_q;
	logic               ext0_request_flag_q;
	logic               ext1_request_flag_q;
	logic               tmr0_overflow_flag_q;
	logic               tmr1_overflow_flag_q;
	logic               serial_rx_flag_q;
	logic               serial_tx_flag_q;
	logic               tmr2_event_flag_q;
	logic               watchdog_irq_flag_q;
	logic               ext2_request_flag_q;
	logic               ext3_request_flag_q;
	logic               net_engine_request_flag_q;
	logic               net_prev_q;
	logic               ins_hi_q;
	logic               ins_lo_q;
	logic [3:0]         src_idx_q;
	core_irq_t          core_q;
	logic [7:0]         evt_status_q;
	logic [7:0]         evt_en_q;
	logic               irq_q;

	// Synchronised pins
	logic [3:0] pin_level_n;
	logic [3:0] pin_fall;

	pin_edge_sync #(
		.WIDTH   (4)
	) u_pin_sync (
		.clock   (CLOCK),
		.reset   (RESET),
		.pin_n   ({EXT_IRQ3_PIN_N, EXT_IRQ2_PIN_N, EXT_IRQ1_PIN_N, EXT_IRQ0_PIN_N}),
		.level_n (pin_level_n),
		.fall    (pin_fall)
	);

	// Write channel handling
	wire do_wr  = aw_full_q & w_full_q & ~bvalid_q;
	wire wr_ok  = do_wr & wlane_q;
	wire wr_tc  = wr_ok & addr_is(awaddr_q, TMRCTL_ADDR);
	wire wr_ien = wr_ok & addr_is(awaddr_q, IRQEN_ADDR);
	wire wr_ipr = wr_ok & addr_is(awaddr_q, IRQPRI_ADDR);
	wire wr_xen = wr_ok & addr_is(awaddr_q, XIRQEN_ADDR);
	wire wr_xpr = wr_ok & addr_is(awaddr_q, XIRQPRI_ADDR);
	wire wr_xfl = wr_ok & addr_is(awaddr_q, XFLAG_ADDR);
	wire wr_afl = wr_ok & addr_is(awaddr_q, AUXFLAG_ADDR);
	wire wr_ecl = wr_ok & addr_is(awaddr_q, EVT_CLEAR_ADDR);
	wire wr_een = wr_ok & addr_is(awaddr_q, EVT_ENABLE_ADDR);

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = addr_is(a, TMRCTL_ADDR) | addr_is(a, IRQEN_ADDR)
			| addr_is(a, IRQPRI_ADDR) | addr_is(a, XIRQEN_ADDR)
			| addr_is(a, XIRQPRI_ADDR) | addr_is(a, XFLAG_ADDR)
			| addr_is(a, AUXFLAG_ADDR) | addr_is(a, CORESTATE_ADDR)
			| addr_is(a, EVT_STATUS_ADDR) | addr_is(a, EVT_CLEAR_ADDR)
			| addr_is(a, EVT_ENABLE_ADDR);
	endfunction

	wire aw_full_d = do_wr ? 1'b0 : (aw_full_q | (AWVALID & awready_q));
	wire w_full_d  = do_wr ? 1'b0 : (w_full_q | (WVALID & wready_q));
	wire bvalid_d  = do_wr | (bvalid_q & ~BREADY);
	wire ar_take   = ARVALID & arready_q;
	wire rvalid_d  = ar_take | (rvalid_q & ~RREADY);

	// Core handshake
	wire ack_valid = INT_ACK & core_q.req;
	wire [NUM_SRC-1:0] ack_clr = ack_valid ? (NUM_SRC'(1) << src_idx_q) : '0;
	wire ret_hi    = INT_RETURN & ins_hi_q;
	wire ret_lo    = INT_RETURN & ~ins_hi_q & ins_lo_q;

	// Network engine falling edge, same clock domain
	wire net_fall = net_prev_q & ~NET_ENGINE_IRQ_N;

	// Source vectors in natural priority order
	wire [NUM_SRC-1:0] pending = {watchdog_irq_flag_q, net_engine_request_flag_q,
		ext3_request_flag_q, ext2_request_flag_q, tmr2_event_flag_q,
		serial_rx_flag_q | serial_tx_flag_q, tmr1_overflow_flag_q,
		ext1_request_flag_q, tmr0_overflow_flag_q, ext0_request_flag_q};
	wire [NUM_SRC-1:0] enabled = {xen_q[XB_WDT], xen_q[XB_NET], xen_q[XB_EXT3],
		xen_q[XB_EXT2], ien_q[5:0]};
	wire [NUM_SRC-1:0] high_sel = {xpri_q[XB_WDT], xpri_q[XB_NET], xpri_q[XB_EXT3],
		xpri_q[XB_EXT2], ipri_q[5:0]};
	wire [NUM_SRC-1:0] ready = pending & enabled & {NUM_SRC{ien_q[IEN_GLOBAL]}};
	wire [NUM_SRC-1:0] hi_req = ready & high_sel;
	wire [NUM_SRC-1:0] lo_req = ready & ~high_sel;

	// High may preempt low; low waits for any handler to finish
	wire take_hi = (|hi_req) & ~ins_hi_q & ~ack_valid;
	wire take_lo = ~take_hi & (|lo_req) & ~ins_hi_q & ~ins_lo_q & ~ack_valid;
	wire [3:0] pick = take_hi ? first_src(hi_req) : first_src(lo_req);

	core_irq_t core_d;
	assign core_d.req    = take_hi | take_lo;
	assign core_d.high   = take_hi;
	assign core_d.number = NUMBERS[pick*4 +: 4];
	assign core_d.vector = VECTORS[pick*8 +: 8];

	// Request flags
	wire [7:0] wd = wdata_q;
	wire ext0_d = (wr_tc ? wd[TC_EXT0_EDGE] : ext0_edge_select_q)
		? flag_next(ext0_request_flag_q, pin_fall[0], wr_tc, wd[TC_EXT0_FLAG], ack_clr[0])
		: ~pin_level_n[0];
	wire ext1_d = (wr_tc ? wd[TC_EXT1_EDGE] : ext1_edge_select_q)
		? flag_next(ext1_request_flag_q, pin_fall[1], wr_tc, wd[TC_EXT1_FLAG], ack_clr[2])
		: ~pin_level_n[1];
	wire tmr0_d = flag_next(tmr0_overflow_flag_q, TMR0_OVERFLOW, wr_tc,
		wd[TC_TMR0_FLAG], ack_clr[1]);
	wire tmr1_d = flag_next(tmr1_overflow_flag_q, TMR1_OVERFLOW, wr_tc,
		wd[TC_TMR1_FLAG], ack_clr[3]);
	wire rx_d   = flag_next(serial_rx_flag_q, SERIAL_RX_DONE, wr_afl, wd[AF_RX], 1'b0);
	wire tx_d   = flag_next(serial_tx_flag_q, SERIAL_TX_DONE, wr_afl, wd[AF_TX], 1'b0);
	wire t2_d   = flag_next(tmr2_event_flag_q, TMR2_EVENT, wr_afl, wd[AF_TMR2], 1'b0);
	wire wdt_d  = flag_next(watchdog_irq_flag_q, WATCHDOG_EVENT, wr_afl, wd[AF_WDT], 1'b0);
	wire ext2_d = flag_next(ext2_request_flag_q, pin_fall[2], wr_xfl, wd[XB_EXT2], 1'b0);
	wire ext3_d = flag_next(ext3_request_flag_q, pin_fall[3], wr_xfl, wd[XB_EXT3], 1'b0);
	wire net_d  = flag_next(net_engine_request_flag_q, net_fall, wr_xfl, wd[XB_NET], 1'b0);

	// In-service levels and events
	wire ins_hi_d = (ins_hi_q & ~ret_hi) | (ack_valid & core_q.high);
	wire ins_lo_d = (ins_lo_q & ~ret_lo) | (ack_valid & ~core_q.high);
	wire [7:0] events = {5'h00, INT_RETURN & ~ins_hi_q & ~ins_lo_q,
		ack_valid & core_q.high & ins_lo_q, core_d.req & ~core_q.req};
	wire [7:0] evt_en_d     = wr_een ? (wd & EVT_MASK) : evt_en_q;
	wire [7:0] evt_status_d = (evt_status_q & ~(wr_ecl ? wd : 8'h00)) | events;

	// Read data selection
	wire [7:0] tc_read = {tmr1_overflow_flag_q, 1'b0, tmr0_overflow_flag_q, 1'b0,
		ext1_request_flag_q, ext1_edge_select_q, ext0_request_flag_q, ext0_edge_select_q};
	wire [7:0] xfl_read = {4'h0, net_engine_request_flag_q, 1'b0,
		ext3_request_flag_q, ext2_request_flag_q};
	wire [7:0] afl_read = {4'h0, watchdog_irq_flag_q, tmr2_event_flag_q,
		serial_tx_flag_q, serial_rx_flag_q};
	wire [7:0] state_read = {ins_hi_q, ins_lo_q, core_q.req, core_q.high, core_q.number};
	wire [7:0] rd_byte =
		addr_is(ARADDR, TMRCTL_ADDR)     ? tc_read :
		addr_is(ARADDR, IRQEN_ADDR)      ? ien_q :
		addr_is(ARADDR, IRQPRI_ADDR)     ? ipri_q :
		addr_is(ARADDR, XIRQEN_ADDR)     ? xen_q :
		addr_is(ARADDR, XIRQPRI_ADDR)    ? xpri_q :
		addr_is(ARADDR, XFLAG_ADDR)      ? xfl_read :
		addr_is(ARADDR, AUXFLAG_ADDR)    ? afl_read :
		addr_is(ARADDR, CORESTATE_ADDR)  ? state_read :
		addr_is(ARADDR, EVT_STATUS_ADDR) ? evt_status_q :
		addr_is(ARADDR, EVT_ENABLE_ADDR) ? evt_en_q :
		8'h00;

	// Bus slave registers
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			awready_q <= 1'b0;
			aw_full_q <= 1'b0;
			awaddr_q  <= '0;
			wready_q  <= 1'b0;
			w_full_q  <= 1'b0;
			wdata_q   <= 8'h00;
			wlane_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end
		else
		begin
			awready_q <= ~aw_full_d & ~bvalid_d;
			aw_full_q <= aw_full_d;
			wready_q  <= ~w_full_d & ~bvalid_d;
			w_full_q  <= w_full_d;
			bvalid_q  <= bvalid_d;
			if (AWVALID & awready_q)
				awaddr_q <= AWADDR;
			if (WVALID & wready_q)
			begin
				wdata_q <= WDATA[7:0];
				wlane_q <= WSTRB[0];
			end
			if (do_wr)
				bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end
		else
		begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_take)
			begin
				rdata_q <= {24'h00_0000, rd_byte};
				rresp_q <= mapped(ARADDR) ? RESP_OKAY : RESP_DECERR;
			end
		end
	end

	// Control registers
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			ien_q              <= IRQEN_RST;
			ipri_q             <= IRQPRI_RST;
			xen_q              <= XIRQEN_RST;
			xpri_q             <= XIRQPRI_RST;
			ext0_edge_select_q <= TMRCTL_RST[TC_EXT0_EDGE];
			ext1_edge_select_q <= TMRCTL_RST[TC_EXT1_EDGE];
			evt_en_q           <= EVT_RST;
		end
		else
		begin
			if (wr_ien)
				ien_q <= wd & IRQEN_MASK;
			if (wr_ipr)
				ipri_q <= wd & IRQPRI_MASK;
			if (wr_xen)
				xen_q <= wd & XIRQ_MASK;
			if (wr_xpr)
				xpri_q <= wd & XIRQ_MASK;
			if (wr_tc)
			begin
				ext0_edge_select_q <= wd[TC_EXT0_EDGE];
				ext1_edge_select_q <= wd[TC_EXT1_EDGE];
			end
			evt_en_q <= evt_en_d;
		end
	end

	// Request flags and arbitration state
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			ext0_request_flag_q       <= TMRCTL_RST[TC_EXT0_FLAG];
			ext1_request_flag_q       <= TMRCTL_RST[TC_EXT1_FLAG];
			tmr0_overflow_flag_q      <= TMRCTL_RST[TC_TMR0_FLAG];
			tmr1_overflow_flag_q      <= TMRCTL_RST[TC_TMR1_FLAG];
			serial_rx_flag_q          <= FLAG_RST[AF_RX];
			serial_tx_flag_q          <= FLAG_RST[AF_TX];
			tmr2_event_flag_q         <= FLAG_RST[AF_TMR2];
			watchdog_irq_flag_q       <= FLAG_RST[AF_WDT];
			ext2_request_flag_q       <= FLAG_RST[XB_EXT2];
			ext3_request_flag_q       <= FLAG_RST[XB_EXT3];
			net_engine_request_flag_q <= FLAG_RST[XB_NET];
			net_prev_q                <= 1'b1;
			ins_hi_q                  <= 1'b0;
			ins_lo_q                  <= 1'b0;
			src_idx_q                 <= 4'h0;
			core_q                    <= '0;
			evt_status_q              <= EVT_RST;
			irq_q                     <= 1'b0;
		end
		else
		begin
			ext0_request_flag_q       <= ext0_d;
			ext1_request_flag_q       <= ext1_d;
			tmr0_overflow_flag_q      <= tmr0_d;
			tmr1_overflow_flag_q      <= tmr1_d;
			serial_rx_flag_q          <= rx_d;
			serial_tx_flag_q          <= tx_d;
			tmr2_event_flag_q         <= t2_d;
			watchdog_irq_flag_q       <= wdt_d;
			ext2_request_flag_q       <= ext2_d;
			ext3_request_flag_q       <= ext3_d;
			net_engine_request_flag_q <= net_d;
			net_prev_q                <= NET_ENGINE_IRQ_N;
			ins_hi_q                  <= ins_hi_d;
			ins_lo_q                  <= ins_lo_d;
			src_idx_q                 <= pick;
			core_q                    <= core_d;
			evt_status_q              <= evt_status_d;
			irq_q                     <= |(evt_status_d & evt_en_d);
		end
	end

	// Outputs
	assign AWREADY  = awready_q;
	assign WREADY   = wready_q;
	assign BVALID   = bvalid_q;
	assign BRESP    = bresp_q;
	assign ARREADY  = arready_q;
	assign RVALID   = rvalid_q;
	assign RDATA    = rdata_q;
	assign RRESP    = rresp_q;
	assign CORE_IRQ = core_q;
	assign IRQ      = irq_q;

endmodule

// ==== test/core_model.sv ====
// Behavioural processor core serving interrupt requests
`timescale 1ns/100ps
module core_model
	import irq_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Request and pacing
	input  wire core_irq_t  irq,
	input  wire logic       slow,
	input  wire logic [7:0] run_len,
	// Core pulses
	output logic            int_ack,
	output logic            int_return,
	// Service record
	output logic [7:0]      last_vec,
	output logic [7:0]      acks,
	output logic [3:0]      depth
);
	logic [7:0] run_q;
	logic [1:0] wait_q;
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			{int_ack, int_return, last_vec, acks, depth, run_q, wait_q} <= '0;
		else
		begin
			int_ack <= 1'b0;
			int_return <= 1'b0;
			if (irq.req && !int_ack && (!slow || wait_q == 2'h3))
			begin
				int_ack <= 1'b1;
				last_vec <= irq.vector;
				acks <= acks + 8'h1;
				depth <= depth + 4'h1;
				run_q <= 8'h00;
				wait_q <= 2'h0;
			end
			else if (irq.req && !int_ack)
				wait_q <= wait_q + 2'h1;
			else if (depth != 4'h0 && !int_ack && !int_return)
			begin
				run_q <= run_q + 8'h1;
				if (run_q == run_len)
				begin
					int_return <= 1'b1;
					depth <= depth - 4'h1;
				end
			end
		end
	end
endmodule

// ==== test/irq_ctrl_checker.sv ====
// Port-level assertions of the interrupt controller
`timescale 1ns/100ps
module irq_ctrl_checker
	import irq_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic       CLOCK,
	input wire logic       RESET,
	// Write response
	input wire logic       BVALID,
	input wire logic       BREADY,
	input wire logic [1:0] BRESP,
	// Core link
	input wire logic       INT_ACK,
	input wire logic       INT_RETURN,
	input wire core_irq_t  CORE_IRQ
);
	localparam logic [7:0] VT [16] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h00,
		8'h00, 8'h43, 8'h4B, 8'h00, 8'h5B, 8'h63, 8'h00, 8'h00, 8'h00};
	logic take;
	logic hi_q;
	logic lo_q;
	assign take = INT_ACK && CORE_IRQ.req;
	// In-service levels seen from the core link
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			hi_q <= 1'b0;
		else if (take && CORE_IRQ.high)
			hi_q <= 1'b1;
		else if (INT_RETURN)
			hi_q <= 1'b0;
	end
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			lo_q <= 1'b0;
		else if (take && !CORE_IRQ.high)
			lo_q <= 1'b1;
		else if (INT_RETURN && !hi_q)
			lo_q <= 1'b0;
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);
	property p_vec_ext0;
		CORE_IRQ.req && CORE_IRQ.number == 4'h0 |-> CORE_IRQ.vector == 8'h03;
	endproperty
	a_vec_ext0: assert property (p_vec_ext0)
		else $error("ext0 vector wrong");
	property p_vec_ext1;
		CORE_IRQ.req && CORE_IRQ.number == 4'h2 |-> CORE_IRQ.vector == 8'h13;
	endproperty
	a_vec_ext1: assert property (p_vec_ext1)
		else $error("ext1 vector wrong");
	property p_vec_rest;
		CORE_IRQ.req |-> CORE_IRQ.vector == VT[CORE_IRQ.number];
	endproperty
	a_vec_rest: assert property (p_vec_rest)
		else $error("vector does not match number");
	property p_num_ok;
		CORE_IRQ.req |-> CORE_IRQ.number < 4'hD && CORE_IRQ.vector != 8'h00;
	endproperty
	a_num_ok: assert property (p_num_ok)
		else $error("reserved interrupt number offered");
	property p_hi_only;
		hi_q |-> !CORE_IRQ.req;
	endproperty
	a_hi_only: assert property (p_hi_only)
		else $error("request offered during high handler");
	property p_lo_wait;
		lo_q |-> !(CORE_IRQ.req && !CORE_IRQ.high);
	endproperty
	a_lo_wait: assert property (p_lo_wait)
		else $error("low request offered during handler");
	property p_ack_drop;
		take |=> !CORE_IRQ.req;
	endproperty
	a_ack_drop: assert property (p_ack_drop)
		else $error("request kept after acknowledge");
	property p_b_hold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
endmodule

// ==== test/two_level_irq_ctrl_tb.sv ====
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
module two_level_irq_ctrl_tb
	import irq_ctrl_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0]  aa = 8'h00, ra = 8'h00, wd = 8'h00, rv, run_len = 8'h3C;
	logic [3:0]  pin_n = 4'hF, depth;
	logic [5:0]  ev = 6'h00;
	logic        net_n = 1'b1, slow = 1'b0;
	logic        awr, wrdy, bvalid, arr, rvalid, ack, ret, irq;
	logic [1:0]  bresp, rresp, br, rr;
	logic [31:0] rdata;
	logic [7:0]  lvec, acks;
	core_irq_t   cirq;
	int          miscompares = 0;
	int          num_checks = 0;
	two_level_irq_ctrl dut (.CLOCK(clock), .RESET(rst), .AWVALID(awv), .AWREADY(awr),
		.AWADDR(aa), .WVALID(wv), .WREADY(wrdy), .WDATA({24'h0, wd}), .WSTRB(4'hF),
		.BVALID(bvalid), .BREADY(bry), .BRESP(bresp), .ARVALID(arv), .ARREADY(arr),
		.ARADDR(ra), .RVALID(rvalid), .RREADY(rry), .RDATA(rdata), .RRESP(rresp),
		.EXT_IRQ0_PIN_N(pin_n[0]), .EXT_IRQ1_PIN_N(pin_n[1]), .EXT_IRQ2_PIN_N(pin_n[2]),
		.EXT_IRQ3_PIN_N(pin_n[3]), .NET_ENGINE_IRQ_N(net_n), .TMR0_OVERFLOW(ev[0]),
		.TMR1_OVERFLOW(ev[1]), .TMR2_EVENT(ev[2]), .SERIAL_TX_DONE(ev[4]),
		.SERIAL_RX_DONE(ev[3]), .WATCHDOG_EVENT(ev[5]), .INT_ACK(ack),
		.INT_RETURN(ret), .CORE_IRQ(cirq), .IRQ(irq));
	core_model core (.clock(clock), .reset(rst), .irq(cirq), .slow(slow),
		.run_len(run_len), .int_ack(ack), .int_return(ret), .last_vec(lvec),
		.acks(acks), .depth(depth));
	initial
	begin
		forever #2 clock = ~clock;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		{awv, wv} <= 2'h3;
		aa <= a;
		wd <= d;
		// Late response ready keeps the response pending a cycle
		forever
		begin
			@(posedge clock);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
			if (bvalid && bry)
				break;
			if (bvalid)
				bry <= 1'b1;
		end
		br = bresp;
		bry <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		{arv, rry} <= 2'h3;
		ra <= a;
		forever
		begin
			@(posedge clock);
			if (arr)
				arv <= 1'b0;
			if (rvalid)
				break;
		end
		rv = rdata[7:0];
		rr = rresp;
		rry <= 1'b0;
		chk(rv, e);
	endtask
	task automatic en2(input logic [7:0] ie, input logic [7:0] xe);
		wr(XIRQEN_ADDR, xe);
		wr(IRQEN_ADDR, ie);
	endtask
	task automatic pulse(input logic [5:0] m);
		@(posedge clock);
		ev <= m;
		@(posedge clock);
		ev <= 6'h00;
	endtask
	task automatic t_regs();
		logic [7:0] ad [4] = '{IRQEN_ADDR, IRQPRI_ADDR, XIRQEN_ADDR, XIRQPRI_ADDR};
		logic [7:0] mk [4] = '{8'hBF, 8'h3F, 8'h1B, 8'h1B};
		rc(TMRCTL_ADDR, TMRCTL_RST);
		for (int i = 0; i < 4; i++)
		begin
			rc(ad[i], 8'h00);
			wr(ad[i], 8'hFF);
			rc(ad[i], mk[i]);
			wr(ad[i], 8'h00);
		end
		wr(8'h04, 8'hFF);
		chk({6'h0, br}, {6'h0, RESP_DECERR});
		rc(8'h04, 8'h00);
		chk({6'h0, rr}, {6'h0, RESP_DECERR});
		$display("register test done");
	endtask
	task automatic t_vec();
		logic [7:0] fa [10] = '{TMRCTL_ADDR, TMRCTL_ADDR, TMRCTL_ADDR, TMRCTL_ADDR,
			AUXFLAG_ADDR, AUXFLAG_ADDR, XFLAG_ADDR, XFLAG_ADDR, XFLAG_ADDR, AUXFLAG_ADDR};
		logic [7:0] fv [10] = '{8'h03, 8'h20, 8'h0C, 8'h80, 8'h01, 8'h04, 8'h01, 8'h02,
			8'h08, 8'h08};
		logic [7:0] vc [10] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h43, 8'h4B,
			8'h5B, 8'h63};
		logic [7:0] en [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h01, 8'h02,
			8'h08, 8'h10};
		logic [7:0] n;
		logic [7:0] ie;
		logic [7:0] xe;
		for (int i = 0; i < 10; i++)
		begin
			n = acks;
			ie = i < 6 ? en[i] : 8'h00;
			xe = i < 6 ? 8'h00 : en[i];
			slow <= i[0];
			wr(fa[i], fv[i]);
			en2(ie, xe);
			idle(8);
			chk(acks, n);
			en2(8'h80, 8'h00);
			idle(8);
			chk(acks, n);
			en2(8'h80 | ie, xe);
			wait (acks == n + 8'h1);
			chk(lvec, vc[i]);
			rc(fa[i], i < 4 ? fv[i] & 8'h05 : fv[i]);
			wr(fa[i], 8'h00);
			en2(8'h00, 8'h00);
			wait (depth == 4'h0);
		end
		$display("vector test done");
	endtask
	task automatic t_prio();
		logic [7:0] n;
		n = acks;
		run_len <= 8'h50;
		wr(IRQPRI_ADDR, 8'h20);
		en2(8'hB8, 8'h00);
		pulse(6'h0A);
		wait (acks == n + 8'h1);
		chk(lvec, 8'h1B);
		pulse(6'h04);
		wait (acks == n + 8'h2);
		chk(lvec, 8'h2B);
		wr(AUXFLAG_ADDR, 8'h00);
		wait (depth == 4'h0);
		chk(acks, n + 8'h2);
		en2(8'h00, 8'h00);
		wr(IRQPRI_ADDR, 8'h00);
		$display("priority test done");
	endtask
	task automatic t_irq();
		logic [7:0] n;
		n = acks;
		rc(EVT_STATUS_ADDR, 8'h03);
		wr(EVT_CLEAR_ADDR, 8'h07);
		rc(EVT_STATUS_ADDR, 8'h00);
		rc(EVT_CLEAR_ADDR, 8'h00);
		wr(EVT_ENABLE_ADDR, 8'h01);
		en2(8'h82, 8'h00);
		pulse(6'h01);
		wait (acks == n + 8'h1);
		idle(2);
		chk({7'h0, irq}, 8'h01);
		wr(EVT_ENABLE_ADDR, 8'h00);
		idle(2);
		chk({7'h0, irq}, 8'h00);
		wr(EVT_ENABLE_ADDR, 8'h01);
		idle(2);
		chk({7'h0, irq}, 8'h01);
		wr(EVT_CLEAR_ADDR, 8'h01);
		idle(2);
		chk({7'h0, irq}, 8'h00);
		wait (depth == 4'h0);
		en2(8'h00, 8'h00);
		$display("event interrupt test done");
	endtask
	task automatic t_pin();
		wr(TMRCTL_ADDR, 8'h01);
		@(posedge clock);
		pin_n <= 4'h0;
		net_n <= 1'b0;
		idle(5);
		rc(TMRCTL_ADDR, 8'h0B);
		rc(XFLAG_ADDR, 8'h0B);
		wr(TMRCTL_ADDR, 8'h01);
		rc(TMRCTL_ADDR, 8'h09);
		@(posedge clock);
		pin_n <= 4'hF;
		net_n <= 1'b1;
		idle(5);
		rc(TMRCTL_ADDR, 8'h01);
		wr(XFLAG_ADDR, 8'h00);
		rc(XFLAG_ADDR, 8'h00);
		pulse(6'h30);
		rc(AUXFLAG_ADDR, 8'h0A);
		wr(AUXFLAG_ADDR, 8'h00);
		rc(AUXFLAG_ADDR, 8'h00);
		wr(TMRCTL_ADDR, 8'h00);
		$display("pin test done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#100000;
		miscompares++;
		end_sim();
	end
	initial
	begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		idle(2);
		t_regs();
		t_vec();
		t_prio();
		t_irq();
		t_pin();
		end_sim();
	end
endmodule
bind two_level_irq_ctrl irq_ctrl_checker chk_i (.CLOCK(CLOCK), .RESET(RESET),
	.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .INT_ACK(INT_ACK),
	.INT_RETURN(INT_RETURN), .CORE_IRQ(CORE_IRQ));
